/* src/sip_pkg.sv */
/*
 * sip_pkg: constants, instruction layout and state types for the serial
 * in-system programming port.
 * Assumes a 25 MHz core clock; the wait delays are converted to core cycles.
 */
package sip_pkg;

    // core clock and self-timed wait delays, times in ns
    localparam int CLK_PERIOD_NS = 40;
    localparam int FLASH_PAGE_WAIT_NS = 4500000;
    localparam int EEPROM_BYTE_WAIT_NS = 9000000;
    localparam int ERASE_WAIT_NS = 9000000;
    localparam int FLASH_PAGE_WAIT_CYC =
        (FLASH_PAGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EEPROM_BYTE_WAIT_CYC =
        (EEPROM_BYTE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_WAIT_CYC =
        (ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CNT_W = 18;

    // memory geometry
    localparam int FLASH_WORD_AW = 14;
    localparam int PAGE_WORD_AW = 6;
    localparam int EEPROM_AW = 10;

    // serial framing
    localparam logic [4:0] LAST_BIT = 5'h1F;
    localparam logic [2:0] BYTE_START = 3'h0;
    localparam logic [1:0] READ_BYTE_IDX = 2'h3;
    localparam logic [1:0] FIRST_BYTE_IDX = 2'h0;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // instruction codes
    localparam logic [7:0] OPC_PROG_ENABLE = 8'hAC;
    localparam logic [7:0] ENABLE_KEY = 8'h53;
    localparam logic [2:0] ERASE_TAG = 3'h4;
    localparam logic [3:0] OPC_READ_FLASH = 4'h2;
    localparam logic [3:0] OPC_LOAD_PAGE = 4'h4;
    localparam logic [2:0] OPC_LOW_ZERO = 3'h0;
    localparam int HIGH_BYTE_BIT = 3;
    localparam logic [7:0] OPC_WRITE_PAGE = 8'h4C;
    localparam logic [7:0] OPC_READ_EEPROM = 8'hA0;
    localparam logic [7:0] OPC_WRITE_EEPROM = 8'hC0;

    // one four-byte instruction as it arrives, first byte in the top
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] data;
    } sip_instr_s;

    typedef enum logic [3:0] {
        SIP_OP_NONE = 4'b0001,
        SIP_OP_FLASH = 4'b0010,
        SIP_OP_EEPROM = 4'b0100,
        SIP_OP_ERASE = 4'b1000
    } sip_op_e;

    typedef enum logic [1:0] {
        SIP_T_IDLE = 2'b01,
        SIP_T_RUN = 2'b10
    } sip_timer_e;

endpackage : sip_pkg

/* src/sip_isp_port.sv */
/*
 * sip_isp_port: serial in-system programming port with its own flash and
 * EEPROM arrays, page buffer and self-timed write delays.
 * Assumes the programmer is the serial master on isp_sck/isp_mosi, holds
 * isp_reset_n low for the whole session, and that isp_sck stands still
 * between instructions. Link logic runs on isp_sck; the wait timer runs on
 * sys_clk.
 */
// Notes on behaviour
// - serial programming only while reset pin low
// - program and erase ignored before programming enable
// - EEPROM write overwrites byte, no erase needed
// - chip erase sets flash and EEPROM to FF
// - input data sampled on rising clock edge
// - output data shifted on falling clock edge
// - second enable byte echoed during third byte
// - page write stores whole buffered page
// - read returns stored content of location
// - page under programming reads FF until done
// - EEPROM byte under programming reads FF
// - reset pin high ends programming mode
// - enable is AC 53 then two spare bytes
// - chip erase is AC then 100x xxxx
// - EEPROM write is C0, address, data
`timescale 1ns/1ps
`default_nettype none

module sip_isp_port
    import sip_pkg::*;
#(
    parameter int unsigned FLASH_WAIT_CYC = sip_pkg::FLASH_PAGE_WAIT_CYC,
    parameter int unsigned EEPROM_WAIT_CYC = sip_pkg::EEPROM_BYTE_WAIT_CYC,
    parameter int unsigned ERASE_CYC = sip_pkg::ERASE_WAIT_CYC
)
(
    // core clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // programming pins
    input wire logic isp_reset_n,
    input wire logic isp_sck,
    input wire logic isp_mosi,
    output logic isp_miso,
    // status towards the core
    output logic prog_mode,
    output logic program_busy
);
    import sip_pkg::*;

    localparam int FLASH_BYTES = 2 ** (FLASH_WORD_AW + 1);
    localparam int PAGE_BYTES = 2 ** (PAGE_WORD_AW + 1);
    localparam int EEPROM_BYTES = 2 ** EEPROM_AW;
    localparam int PAGE_AW = FLASH_WORD_AW - PAGE_WORD_AW;

    // ---------------- link domain (isp_sck) ----------------
    logic link_rst;
    logic [4:0] bit_cnt;
    logic [30:0] rx;
    logic enabled;
    logic req_tgl;
    sip_op_e op_kind;
    logic [PAGE_AW-1:0] busy_page;
    logic [EEPROM_AW-1:0] busy_ee;
    logic [7:0] tx;
    logic done_s1;
    logic done_s2;
    logic done_tgl;
    logic busy;
    logic last_bit;
    sip_instr_s cur;
    logic [15:0] cur_addr;
    logic [15:0] rx_addr;
    logic is_enable;
    logic is_erase;
    logic is_load;
    logic is_wpage;
    logic is_wee;
    logic accept;
    logic [7:0] rd_byte;

    logic [7:0] flash_mem [FLASH_BYTES];
    logic [7:0] ee_mem [EEPROM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];

    // the pin itself clears the link side: its clock may not run at all
    // a high pin ends the session; while it stays low the link keeps its
    // state between instructions, so a cut frame needs a pin pulse
    assign link_rst = isp_reset_n;
    assign cur = {rx, isp_mosi};
    assign cur_addr = {cur.addr_hi, cur.addr_lo};
    assign rx_addr = rx[15:0];
    assign last_bit = (bit_cnt == LAST_BIT);
    assign busy = (req_tgl != done_s2);
    // loads are refused while busy too; the master waits out the delay
    assign accept = last_bit && enabled && !busy;

    assign is_enable = (cur.opcode == OPC_PROG_ENABLE)
        && (cur.addr_hi == ENABLE_KEY);
    assign is_erase = (cur.opcode == OPC_PROG_ENABLE)
        && (cur.addr_hi[7:5] == ERASE_TAG);
    assign is_load = (cur.opcode[7:4] == OPC_LOAD_PAGE)
        && (cur.opcode[2:0] == OPC_LOW_ZERO);
    assign is_wpage = (cur.opcode == OPC_WRITE_PAGE);
    assign is_wee = (cur.opcode == OPC_WRITE_EEPROM);

    // input shifting, MSB first, on the rising edge
    always_ff @(posedge isp_sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt <= 5'h00;
            rx <= 31'h0000_0000;
        end
        else
        begin
            bit_cnt <= bit_cnt + 5'h01;
            rx <= cur[30:0];
        end
    end

    // programming enable; held until the reset pin goes high
    // a wrong echo changes nothing here; the master decides to resync
    always_ff @(posedge isp_sck or posedge link_rst)
    begin
        if (link_rst)
            enabled <= 1'b0;
        else if (last_bit && is_enable)
            enabled <= 1'b1;
    end

    // launch of self-timed operations; busy lasts until the timer answers
    always_ff @(posedge isp_sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            req_tgl <= 1'b0;
            op_kind <= SIP_OP_NONE;
            busy_page <= '0;
            busy_ee <= '0;
        end
        else if (accept && (is_wpage || is_wee || is_erase))
        begin
            req_tgl <= ~req_tgl;
            if (is_wpage)
            begin
                op_kind <= SIP_OP_FLASH;
                busy_page <= cur_addr[FLASH_WORD_AW-1:PAGE_WORD_AW];
            end
            else if (is_wee)
            begin
                op_kind <= SIP_OP_EEPROM;
                busy_ee <= cur_addr[EEPROM_AW-1:0];
            end
            else
                op_kind <= SIP_OP_ERASE;
        end
    end

    // completion toggle from the timer, two-flop synchroniser
    always_ff @(posedge isp_sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end
        else
        begin
            done_s1 <= done_tgl;
            done_s2 <= done_s1;
        end
    end

    // arrays are written at once; the wait only hides the new content
    // the page buffer is kept after a page write, so bytes that are not
    // loaded again go into the next page unchanged
    always_ff @(posedge isp_sck)
    begin
        if (accept)
        begin
            if (is_load)
                page_buf[{cur.addr_lo[PAGE_WORD_AW-1:0],
                          cur.opcode[HIGH_BYTE_BIT]}] <= cur.data;
            if (is_wpage)
            begin
                for (int i = 0; i < PAGE_BYTES; i++)
                    flash_mem[{cur_addr[FLASH_WORD_AW-1:PAGE_WORD_AW],
                               i[PAGE_WORD_AW:0]}] <= page_buf[i];
            end
            if (is_wee)
                ee_mem[cur_addr[EEPROM_AW-1:0]] <= cur.data;
            if (is_erase)
            begin
                for (int i = 0; i < FLASH_BYTES; i++)
                    flash_mem[i] <= ERASED_BYTE;
                for (int i = 0; i < EEPROM_BYTES; i++)
                    ee_mem[i] <= ERASED_BYTE;
            end
        end
    end

    // fourth output byte: read data, else echo of the byte just taken in
    always_comb
    begin
        rd_byte = rx[7:0];
        if (enabled && (rx[23:20] == OPC_READ_FLASH)
            && (rx[18:16] == OPC_LOW_ZERO))
        begin
            if (busy && (op_kind == SIP_OP_FLASH) && (busy_page ==
                rx_addr[FLASH_WORD_AW-1:PAGE_WORD_AW]))
                rd_byte = ERASED_BYTE;
            else
                rd_byte = flash_mem[{rx_addr[FLASH_WORD_AW-1:0],
                                     rx[16+HIGH_BYTE_BIT]}];
        end
        else if (enabled && (rx[23:16] == OPC_READ_EEPROM))
        begin
            if (busy && (op_kind == SIP_OP_EEPROM)
                && (busy_ee == rx_addr[EEPROM_AW-1:0]))
                rd_byte = ERASED_BYTE;
            else
                rd_byte = ee_mem[rx_addr[EEPROM_AW-1:0]];
        end
    end

    // output shifting on the falling edge; a new byte loads at each boundary
    // byte one always reads zero, giving the master a fixed frame start
    always_ff @(negedge isp_sck or posedge link_rst)
    begin
        if (link_rst)
            tx <= IDLE_BYTE;
        else if (bit_cnt[2:0] == BYTE_START)
        begin
            if (bit_cnt[4:3] == FIRST_BYTE_IDX)
                tx <= IDLE_BYTE;
            else if (bit_cnt[4:3] == READ_BYTE_IDX)
                tx <= rd_byte;
            else
                tx <= rx[7:0];
        end
        else
            tx <= {tx[6:0], 1'b0};
    end

    assign isp_miso = tx[7];

    // ---------------- core domain (sys_clk) ----------------
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic abort;
    sip_timer_e tstate;
    logic [WAIT_CNT_W-1:0] wait_cnt;

    // a session that ends drops a running wait; the arrays already hold
    // the new data, so only the read masking is lost
    assign abort = rst_s2;

    // reset pin and request toggle, two flops each before use
    // rst_s2 high means no session: the pin stands high
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end
        else
        begin
            rst_s1 <= isp_reset_n;
            rst_s2 <= rst_s1;
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            prog_mode <= 1'b0;
        else
            prog_mode <= ~rst_s2;
    end

    // self-timed wait; op_kind is stable while the link is busy
    // one down-counter serves all three waits; only its load value differs
    always_ff @(posedge sys_clk)
    begin
        if (reset || abort)
        begin
            tstate <= SIP_T_IDLE;
            wait_cnt <= '0;
            done_tgl <= 1'b0;
            program_busy <= 1'b0;
        end
        else
        begin
            case (tstate)
                SIP_T_IDLE:
                begin
                    if (req_s2 != req_s3)
                    begin
                        tstate <= SIP_T_RUN;
                        program_busy <= 1'b1;
                        if (op_kind == SIP_OP_FLASH)
                            wait_cnt <= WAIT_CNT_W'(FLASH_WAIT_CYC - 1);
                        else if (op_kind == SIP_OP_EEPROM)
                            wait_cnt <= WAIT_CNT_W'(EEPROM_WAIT_CYC - 1);
                        else
                            wait_cnt <= WAIT_CNT_W'(ERASE_CYC - 1);
                    end
                end
                SIP_T_RUN:
                begin
                    if (wait_cnt == '0)
                    begin
                        tstate <= SIP_T_IDLE;
                        program_busy <= 1'b0;
                        done_tgl <= ~done_tgl;
                    end
                    else
                        wait_cnt <= wait_cnt - WAIT_CNT_W'(1);
                end
                default:
                begin
                    tstate <= SIP_T_IDLE;
                    program_busy <= 1'b0;
                end
            endcase
        end
    end

endmodule : sip_isp_port
`default_nettype wire

/* tb/sip_isp_port_assertions.sv */
/* sip_isp_port_assertions: port checks for sip_isp_port.
   Assumes isp_sck stands low between instructions. */
`timescale 1ns/1ps
`default_nettype none
module sip_isp_port_assertions #(
    parameter int unsigned FLASH_WAIT_CYC = 200
)
(
    // core clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // programming pins
    input wire logic isp_reset_n,
    input wire logic isp_sck,
    input wire logic isp_mosi,
    input wire logic isp_miso,
    // status
    input wire logic prog_mode,
    input wire logic program_busy
);
    logic [4:0] bit_cnt;
    logic [7:0] in_hist;
    logic [31:0] busy_len;

    // mirrors the link side, cleared like it by the reset pin
    always_ff @(posedge isp_sck or posedge isp_reset_n)
    begin
        if (isp_reset_n)
        begin
            bit_cnt <= 5'h00;
            in_hist <= 8'h00;
        end
        else
        begin
            bit_cnt <= bit_cnt + 5'h01;
            in_hist <= {in_hist[6:0], isp_mosi};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || !program_busy)
            busy_len <= 32'h0;
        else
            busy_len <= busy_len + 32'h1;
    end

    mode_enter_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        (!isp_reset_n)[*5] |-> prog_mode)
        else $error("prog_mode missing with reset pin low");
    mode_exit_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        isp_reset_n[*5] |-> !prog_mode)
        else $error("prog_mode kept with reset pin high");
    busy_clear_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        isp_reset_n[*5] |-> !program_busy)
        else $error("program_busy kept with reset pin high");
    busy_mode_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(program_busy) |-> prog_mode)
        else $error("program_busy rose outside programming mode");
    busy_hold_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $rose(program_busy) |=> program_busy[*8])
        else $error("program_busy pulse too short");
    busy_min_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        $fell(program_busy) && prog_mode |-> busy_len >= FLASH_WAIT_CYC)
        else $error("self-timed wait ended early");
    byte_zero_a: assert property (
        @(posedge isp_sck) disable iff (isp_reset_n)
        bit_cnt < 5'h08 |-> !isp_miso)
        else $error("first output byte not zero");
    echo_byte_a: assert property (
        @(posedge isp_sck) disable iff (isp_reset_n)
        bit_cnt >= 5'h08 && bit_cnt < 5'h18 |-> isp_miso == in_hist[7])
        else $error("output bit does not echo input");
endmodule : sip_isp_port_assertions

bind sip_isp_port sip_isp_port_assertions #(
    .FLASH_WAIT_CYC(FLASH_WAIT_CYC)
) u_chk (
    .sys_clk(sys_clk),
    .reset(reset),
    .isp_reset_n(isp_reset_n),
    .isp_sck(isp_sck),
    .isp_mosi(isp_mosi),
    .isp_miso(isp_miso),
    .prog_mode(prog_mode),
    .program_busy(program_busy)
);
`default_nettype wire

/* tb/sip_programmer.sv */
/* sip_programmer: behavioural serial programmer, master of the link.
   Assumes the caller serialises calls to its tasks. */
`timescale 1ns/1ps
`default_nettype none
module sip_programmer
(
    // programming pins
    output logic isp_reset_n,
    output logic isp_sck,
    output logic isp_mosi,
    input wire logic isp_miso
);
    // each clock phase lasts 125 ns, over three core cycles; the clock
    // parks low between frames
    localparam realtime HALF = 125.0;
    // power-up wait before enabling, scaled down to keep runs short; the
    // port itself does not time it
    localparam realtime ENABLE_WAIT = 1000.0;

    initial
    begin
        isp_reset_n = 1'b0;
        isp_sck = 1'b0;
        isp_mosi = 1'b0;
    end

    // high pulse on the reset pin resynchronises the link
    task automatic resync();
        isp_sck = 1'b0;
        isp_reset_n = 1'b1;
        #200;
        isp_reset_n = 1'b0;
        #(ENABLE_WAIT);
    endtask : resync

    task automatic release_pin();
        isp_reset_n = 1'b1;
    endtask : release_pin

    // always the whole four bytes; answer taken at each rising edge
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--)
        begin
            isp_mosi = tx[i];
            #(HALF);
            isp_sck = 1'b1;
            rx[i] = isp_miso;
            #(HALF);
            isp_sck = 1'b0;
        end
        isp_mosi = ~tx[0];
        #(HALF);
    endtask : xfer
endmodule : sip_programmer
`default_nettype wire

/* tb/testbench.sv */
/* testbench: scenarios for sip_isp_port driven through sip_programmer.
   Assumes short self-timed waits set by parameter. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sip_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    wire logic isp_reset_n, isp_sck, isp_mosi, isp_miso;
    wire logic prog_mode, program_busy;
    int miscompares = 0;
    int compares = 0;

    always #20 sys_clk = ~sys_clk;

    sip_isp_port #(
        .FLASH_WAIT_CYC(200),
        .EEPROM_WAIT_CYC(400),
        .ERASE_CYC(300)
    ) u_dut (
        .sys_clk(sys_clk),
        .reset(reset),
        .isp_reset_n(isp_reset_n),
        .isp_sck(isp_sck),
        .isp_mosi(isp_mosi),
        .isp_miso(isp_miso),
        .prog_mode(prog_mode),
        .program_busy(program_busy)
    );

    sip_programmer u_prog (
        .isp_reset_n(isp_reset_n),
        .isp_sck(isp_sck),
        .isp_mosi(isp_mosi),
        .isp_miso(isp_miso)
    );

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [31:0] tx);
        logic [31:0] rx;
        u_prog.xfer(tx, rx);
    endtask : wr

    task automatic rd(input string what, input logic [23:0] cmd,
        input logic [7:0] exp);
        logic [31:0] rx;
        u_prog.xfer({cmd, 8'h00}, rx);
        check(what, rx[7:0], exp);
    endtask : rd

    task automatic wait_ready();
        int n;
        n = 0;
        while (program_busy !== 1'b0)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 1000)
            begin
                miscompares++;
                $display("ERROR program_busy expected 0 seen 1");
                report_and_stop();
            end
        end
    endtask : wait_ready

    task automatic t_enable();
        logic [31:0] rx;
        u_prog.resync();
        u_prog.xfer({OPC_PROG_ENABLE, ENABLE_KEY, 16'h0000}, rx);
        check("byte1 out", rx[31:24], 8'h00);
        check("byte2 out", rx[23:16], OPC_PROG_ENABLE);
        check("enable echo", rx[15:8], ENABLE_KEY);
        check("prog_mode", {7'h00, prog_mode}, 8'h01);
        $display("done t_enable");
    endtask : t_enable

    task automatic t_erase();
        wr({OPC_PROG_ENABLE, 8'h9F, 16'h0000});
        repeat (4) @(posedge sys_clk);
        #1;
        check("erase busy", {7'h00, program_busy}, 8'h01);
        wait_ready();
        rd("erased eeprom", {OPC_READ_EEPROM, 8'h03, 8'hFF}, 8'hFF);
        rd("erased flash", {8'h28, 8'h3F, 8'hFF}, 8'hFF);
        $display("done t_erase");
    endtask : t_erase

    task automatic t_locked();
        u_prog.resync();
        wr({OPC_WRITE_EEPROM, 8'h00, 8'h07, 8'h11});
        repeat (4) @(posedge sys_clk);
        #1;
        check("locked busy", {7'h00, program_busy}, 8'h00);
        t_enable();
        rd("locked eeprom", {OPC_READ_EEPROM, 8'h00, 8'h07}, 8'hFF);
        $display("done t_locked");
    endtask : t_locked

    task automatic t_eeprom();
        wr({OPC_WRITE_EEPROM, 8'h02, 8'h03, 8'h5A});
        rd("eeprom polled", {OPC_READ_EEPROM, 8'h02, 8'h03}, 8'hFF);
        check("eeprom busy", {7'h00, program_busy}, 8'h01);
        wait_ready();
        rd("eeprom data", {OPC_READ_EEPROM, 8'h02, 8'h03}, 8'h5A);
        wr({OPC_WRITE_EEPROM, 8'h02, 8'h03, 8'h3C});
        wait_ready();
        rd("eeprom rewrite", {OPC_READ_EEPROM, 8'h02, 8'h03}, 8'h3C);
        $display("done t_eeprom");
    endtask : t_eeprom

    task automatic t_flash();
        wr({OPC_LOAD_PAGE, 4'h0, 8'h00, 8'h05, 8'hA5});
        wr({OPC_LOAD_PAGE, 4'h8, 8'h00, 8'h05, 8'hC3});
        wr({OPC_WRITE_PAGE, 8'h01, 8'h40, 8'h00});
        rd("flash polled", {8'h20, 8'h01, 8'h45}, 8'hFF);
        wait_ready();
        rd("flash low", {8'h20, 8'h01, 8'h45}, 8'hA5);
        rd("flash high", {8'h28, 8'h01, 8'h45}, 8'hC3);
        $display("done t_flash");
    endtask : t_flash

    task automatic t_exit();
        u_prog.release_pin();
        repeat (8) @(posedge sys_clk);
        #1;
        check("prog_mode off", {7'h00, prog_mode}, 8'h00);
        check("miso idle", {7'h00, isp_miso}, 8'h00);
        $display("done t_exit");
    endtask : t_exit

    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_enable();
        t_erase();
        t_locked();
        t_eeprom();
        t_flash();
        t_exit();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
